/* cts_regs.vh */
// Constants for the communication timeout supervisor
`ifndef CTS_REGS_VH
`define CTS_REGS_VH
`define CTS_CLK_KHZ 40000
`define CTS_TICK_MS 1000
`define CTS_TICK_CYCLES (`CTS_TICK_MS * `CTS_CLK_KHZ)
`define CTS_BOOT_CYCLES 2'd3
`define CTS_EXT_CMD 8'hf8
`define CTS_CFG_B2 8'h05
`define CTS_RD_B2 8'h00
`define CTS_SUP_B3 8'h09
`define CTS_RST_B1 8'h99
`define CTS_RST_B3 8'h00
`define CTS_CFG_LEN 5'd16
`define CTS_RD_LEN 5'd6
`define CTS_RST_LEN 5'd4
`define CTS_CFG_RSP_LEN 5'd8
`define CTS_RD_RSP_LEN 5'd16
`define CTS_FL_RSVD 7
`define CTS_FL_RST_COMM 6
`define CTS_FL_RST_CTRL 5
`define CTS_FL_LINE_B 4
`define CTS_FL_LINE_A 3
`define CTS_FL_AOUT2 1
`define CTS_FL_AOUT1 0
`define CTS_LN_LEVEL 7
`define CTS_LINES 23
`define CTS_GRP_EXT_LO 8
`define CTS_GRP_CTRL_LO 16
`define CTS_GRP_MUX_LO 20
`define CTS_AO_EN 15
`define CTS_RK_HARD 1
`define CTS_RK_SOFT 0
`define CTS_ERR_NONE 8'h00
`define CTS_ERR_CSUM 8'h01
`define CTS_ERR_PARAM 8'h02
`define CTS_REG_CTRL 4'h0
`define CTS_REG_STAT 4'h4
`define CTS_REG_COUNT 4'h8
`define CTS_REG_LIMIT 4'hc
`define CTS_CTRL_HOLD 0
`define CTS_CTRL_CLR 1
`define CTS_STAT_EN 0
`define CTS_STAT_EXP 1
`define CTS_STAT_FORCED 2
`endif

/* cts_tick_div.v */
// Divider giving the supervisor its slow tick enable
`timescale 1ns/1ps
`include "cts_regs.vh"
module cts_tick_div #(
  parameter [31:0] CYCLES = `CTS_TICK_CYCLES
) (
  input wire clk,
  input wire rst_n,
  output wire tick
);
  reg [31:0] cnt_q;
  reg tick_q;

  // One-cycle pulse every CYCLES clocks
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (cnt_q == CYCLES - 32'h00000001) begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;
endmodule

/* cts_frame_rx.v */
// Command frame capture with running byte and word sums
`timescale 1ns/1ps
module cts_frame_rx (
  input wire clk,
  input wire rst_n,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire rx_last,
  output wire [127:0] frame_bytes,
  output wire [4:0] frame_len,
  output wire frame_done,
  output wire [7:0] sum_hdr,
  output wire [7:0] sum_short,
  output wire [15:0] sum_body
);
  reg [7:0] buf_q [0:15];
  reg [4:0] idx_q;
  reg [4:0] len_q;
  reg done_q;
  reg [7:0] hdr_q;
  reg [7:0] all_q;
  reg [15:0] body_q;
  genvar g;

  // Bytes past the sixteenth are counted, not stored
  always @(posedge clk) begin
    if (rx_valid && idx_q < 5'd16) begin
      buf_q[idx_q[3:0]] <= rx_byte;
    end
  end

  // Position, length and sums; byte 0 carries the check itself
  always @(posedge clk) begin
    if (!rst_n) begin
      idx_q <= 5'd0;
      len_q <= 5'd0;
      done_q <= 1'b0;
      hdr_q <= 8'h00;
      all_q <= 8'h00;
      body_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      if (rx_valid) begin
        if (idx_q == 5'd0) begin
          hdr_q <= 8'h00;
          all_q <= 8'h00;
          body_q <= 16'h0000;
        end else begin
          all_q <= all_q + rx_byte;
          if (idx_q < 5'd6) begin
            hdr_q <= hdr_q + rx_byte;
          end else begin
            body_q <= body_q + {8'h00, rx_byte};
          end
        end
        if (rx_last) begin
          done_q <= 1'b1;
          len_q <= idx_q + 5'd1;
          idx_q <= 5'd0;
        end else if (idx_q != 5'd30) begin
          idx_q <= idx_q + 5'd1;
        end
      end
    end
  end

  // Flatten the byte buffer
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_flat
      assign frame_bytes[8*g +: 8] = buf_q[g];
    end
  endgenerate

  assign frame_len = len_q;
  assign frame_done = done_q;
  assign sum_hdr = hdr_q;
  assign sum_short = all_q;
  assign sum_body = body_q;
endmodule

/* cts_supervisor.v */
// Communication timeout supervisor: frame decode, counter and actions
`timescale 1ns/1ps
`include "cts_regs.vh"
// Notes on behaviour
// RULE_01 - Supervisor runs only while the action flags byte is nonzero.
// RULE_02 - Every arriving command frame clears the counter.
// RULE_03 - Outgoing sample packets never clear the counter.
// RULE_04 - Host sends some command periodically while streaming.
// RULE_05 - Counter reaching the limit fires every selected action.
// RULE_06 - Counter ticks about once per second; limit 1 to 65535.
// RULE_07 - Flag bits: 6 comm, 5 control, 4 line B, 3 line A, 1/0 analog.
// RULE_08 - Line action: bit 7 level, bits 4-0 line number 0-22.
// RULE_09 - Lines 0-7, 8-15, 16-19, 20-22 map to the four groups.
// RULE_10 - Analog setting: low byte, then upper nibble plus enable bit 7.
// RULE_11 - Either enable bit enables both outputs; both clear floats them.
// RULE_12 - Bytes 7-10 kept in storage; a change rewrites storage.
// RULE_13 - Host avoids frequent setting changes; storage wears out.
// RULE_14 - Defaults jumper at power-up zeroes bytes 7-10, restores factory.
// RULE_15 - Configure frame header, payload bytes 7-15, echo plus flags.
// RULE_16 - Readback frame answers error code and all settings.
// RULE_17 - Restart frame: bit 1 hard, bit 0 soft, both processors.
// RULE_18 - Frames failing sum checks are not applied; error returned.
module cts_supervisor #(
  parameter [31:0] TICK_CYCLES = `CTS_TICK_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output wire [31:0] rdata,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire rx_last,
  output wire [7:0] resp_byte,
  output wire resp_valid,
  output wire resp_last,
  input wire resp_ready,
  input wire defaults_jumper,
  input wire [7:0] nv_flags_in,
  input wire [15:0] nv_limit_in,
  input wire [7:0] nv_line_a_in,
  output wire nv_commit,
  output wire [7:0] nv_flags,
  output wire [15:0] nv_limit,
  output wire [7:0] nv_line_a,
  output wire factory_restore,
  output wire reset_comm,
  output wire reset_control,
  output wire restart_hard,
  output wire restart_soft,
  output wire [7:0] flexible_line_group_out,
  output wire [7:0] flexible_line_group_oe,
  output wire [7:0] extended_line_group_out,
  output wire [7:0] extended_line_group_oe,
  output wire [3:0] control_line_group_out,
  output wire [3:0] control_line_group_oe,
  output wire [2:0] multiplexer_line_group_out,
  output wire [2:0] multiplexer_line_group_oe,
  output wire [11:0] aout_first_code,
  output wire [11:0] aout_second_code,
  output wire aout_enable,
  output wire aout_load
);
  wire [127:0] fb;
  wire [4:0] flen;
  wire fdone;
  wire [7:0] sum_hdr;
  wire [7:0] sum_short;
  wire [15:0] sum_body;
  wire tick;
  reg [7:0] timeout_action_flags;
  reg [15:0] expiry_count_limit;
  reg [7:0] line_action_a;
  reg [7:0] line_action_b;
  reg [15:0] analog_output_first_setting;
  reg [15:0] analog_output_second_setting;
  reg [15:0] count_q;
  reg fire_q;
  reg hold_q;
  reg expired_q;
  reg jmp_s1_q;
  reg jmp_s2_q;
  reg [1:0] boot_q;
  reg commit_q;
  reg factory_q;
  reg rst_comm_q;
  reg rst_ctrl_q;
  reg hard_q;
  reg soft_q;
  reg [22:0] force_q;
  reg [22:0] level_q;
  reg [11:0] ao1_q;
  reg [11:0] ao2_q;
  reg ao_en_q;
  reg ao_load_q;
  reg [127:0] resp_q;
  reg [4:0] resp_cnt_q;
  reg [31:0] rdata_q;
  reg [127:0] rn;
  reg [4:0] rl;
  reg [7:0] cs8;
  reg [15:0] cs16;
  integer k;
  genvar g;

  cts_frame_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .rx_last(rx_last),
    .frame_bytes(fb),
    .frame_len(flen),
    .frame_done(fdone),
    .sum_hdr(sum_hdr),
    .sum_short(sum_short),
    .sum_body(sum_body)
  );

  // RULE_06 slow tick
  cts_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Frame classification from the captured header bytes
  wire is_ext = fb[15:8] == `CTS_EXT_CMD;
  wire is_sup = is_ext && fb[31:24] == `CTS_SUP_B3;
  // RULE_15 configure header
  wire is_cfg = is_sup && fb[23:16] == `CTS_CFG_B2 && flen == `CTS_CFG_LEN;
  // RULE_16 readback header
  wire is_rd = is_sup && fb[23:16] == `CTS_RD_B2 && flen == `CTS_RD_LEN;
  // RULE_17 restart header
  wire is_rst = fb[15:8] == `CTS_RST_B1 && fb[31:24] == `CTS_RST_B3 &&
                flen == `CTS_RST_LEN;
  // RULE_18 sum checks
  wire ext_ok = fb[7:0] == sum_hdr && fb[47:32] == sum_body;
  wire rst_ok = fb[7:0] == sum_short;
  // RULE_07 reserved flag bit must be zero
  wire cfg_bad = fb[56 + `CTS_FL_RSVD];
  wire cfg_take = fdone && is_cfg && ext_ok && !cfg_bad;
  wire rst_take = fdone && is_rst && rst_ok;
  wire [7:0] cfg_err = !ext_ok ? `CTS_ERR_CSUM :
                       cfg_bad ? `CTS_ERR_PARAM : `CTS_ERR_NONE;
  wire [7:0] rd_err = ext_ok ? `CTS_ERR_NONE : `CTS_ERR_CSUM;
  wire [7:0] rst_err = rst_ok ? `CTS_ERR_NONE : `CTS_ERR_CSUM;
  // RULE_12 stored part is bytes 7 to 10
  wire nv_change = fb[87:56] !=
                   {line_action_a, expiry_count_limit[15:8],
                    expiry_count_limit[7:0], timeout_action_flags};
  // RULE_01 enabled whenever any flag is set
  wire sup_enabled = timeout_action_flags != 8'h00;
  wire boot_now = boot_q == `CTS_BOOT_CYCLES - 2'd1;

  // Defaults jumper is a pin; two stages before use
  always @(posedge clk) begin
    if (!rst_n) begin
      jmp_s1_q <= 1'b0;
      jmp_s2_q <= 1'b0;
      boot_q <= 2'd0;
    end else begin
      jmp_s1_q <= defaults_jumper;
      jmp_s2_q <= jmp_s1_q;
      if (boot_q != `CTS_BOOT_CYCLES) begin
        boot_q <= boot_q + 2'd1;
      end
    end
  end

  // Settings: bytes 7-10 loaded from storage at boot, then all from configure frames
  always @(posedge clk) begin
    if (!rst_n) begin
      timeout_action_flags <= 8'h00;
      expiry_count_limit <= 16'h0000;
      line_action_a <= 8'h00;
      line_action_b <= 8'h00;
      analog_output_first_setting <= 16'h0000;
      analog_output_second_setting <= 16'h0000;
      commit_q <= 1'b0;
      factory_q <= 1'b0;
    end else begin
      commit_q <= 1'b0;
      factory_q <= 1'b0;
      if (boot_now) begin
        if (jmp_s2_q) begin
          // RULE_14 jumper zeroes stored bytes
          timeout_action_flags <= 8'h00;
          expiry_count_limit <= 16'h0000;
          line_action_a <= 8'h00;
          commit_q <= 1'b1;
          factory_q <= 1'b1;
        end else begin
          timeout_action_flags <= nv_flags_in;
          expiry_count_limit <= nv_limit_in;
          line_action_a <= nv_line_a_in;
        end
      end else if (cfg_take) begin
        // RULE_10 low byte first in each pair
        timeout_action_flags <= fb[63:56];
        expiry_count_limit <= fb[79:64];
        line_action_a <= fb[87:80];
        line_action_b <= fb[95:88];
        analog_output_first_setting <= fb[111:96];
        analog_output_second_setting <= fb[127:112];
        // RULE_12 rewrite only on change, to spare wear
        commit_q <= nv_change;
      end
    end
  end

  // Supervisor counter; limit zero never expires
  always @(posedge clk) begin
    if (!rst_n) begin
      count_q <= 16'h0000;
      fire_q <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      // RULE_02 any frame clears; RULE_03 sends are not frames
      if (fdone || !sup_enabled) begin
        count_q <= 16'h0000;
      end else if (tick && !hold_q) begin
        // RULE_05 expiry on reaching the limit
        if (expiry_count_limit != 16'h0000 &&
            count_q == expiry_count_limit - 16'h0001) begin
          count_q <= 16'h0000;
          fire_q <= 1'b1;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end

  // Processor resets, analog load and restart pulses
  always @(posedge clk) begin
    if (!rst_n) begin
      rst_comm_q <= 1'b0;
      rst_ctrl_q <= 1'b0;
      hard_q <= 1'b0;
      soft_q <= 1'b0;
      ao1_q <= 12'h000;
      ao2_q <= 12'h000;
      ao_en_q <= 1'b0;
      ao_load_q <= 1'b0;
    end else begin
      // RULE_07 processor reset selects
      rst_comm_q <= fire_q && timeout_action_flags[`CTS_FL_RST_COMM];
      rst_ctrl_q <= fire_q && timeout_action_flags[`CTS_FL_RST_CTRL];
      // RULE_17 restart acts on both processors
      hard_q <= rst_take && fb[16 + `CTS_RK_HARD];
      soft_q <= rst_take && fb[16 + `CTS_RK_SOFT];
      ao_load_q <= 1'b0;
      if (fire_q && (timeout_action_flags[`CTS_FL_AOUT1] ||
                     timeout_action_flags[`CTS_FL_AOUT2])) begin
        ao_load_q <= 1'b1;
        if (timeout_action_flags[`CTS_FL_AOUT1]) begin
          ao1_q <= analog_output_first_setting[11:0];
        end
        if (timeout_action_flags[`CTS_FL_AOUT2]) begin
          ao2_q <= analog_output_second_setting[11:0];
        end
        // RULE_11 shared enable for both outputs
        ao_en_q <= analog_output_first_setting[`CTS_AO_EN] ||
                   analog_output_second_setting[`CTS_AO_EN];
      end
    end
  end

  // Per-line forcing; line B wins when both name one line
  generate
    for (g = 0; g < `CTS_LINES; g = g + 1) begin : g_line
      wire hit_a = timeout_action_flags[`CTS_FL_LINE_A] &&
                   line_action_a[4:0] == g;
      wire hit_b = timeout_action_flags[`CTS_FL_LINE_B] &&
                   line_action_b[4:0] == g;
      // RULE_08 level from bit 7, number from bits 4-0
      always @(posedge clk) begin
        if (!rst_n) begin
          force_q[g] <= 1'b0;
          level_q[g] <= 1'b0;
        end else if (fire_q && hit_b) begin
          force_q[g] <= 1'b1;
          level_q[g] <= line_action_b[`CTS_LN_LEVEL];
        end else if (fire_q && hit_a) begin
          force_q[g] <= 1'b1;
          level_q[g] <= line_action_a[`CTS_LN_LEVEL];
        end
      end
    end
  endgenerate

  // Response image with its own sums, built from the current frame
  always @* begin
    rn = 128'h0;
    rl = 5'd0;
    cs8 = 8'h00;
    cs16 = 16'h0000;
    if (is_rst) begin
      rn[15:8] = `CTS_RST_B1;
      rn[31:24] = rst_err;
      rl = `CTS_RST_LEN;
      for (k = 1; k < 4; k = k + 1) begin
        cs8 = cs8 + rn[8*k +: 8];
      end
    end else if (is_cfg || is_rd) begin
      rn[15:8] = `CTS_EXT_CMD;
      rn[23:16] = `CTS_CFG_B2;
      rn[31:24] = `CTS_SUP_B3;
      if (is_cfg) begin
        rn[55:48] = cfg_err;
        rn[63:56] = cfg_take ? fb[63:56] : timeout_action_flags;
        rl = `CTS_CFG_RSP_LEN;
      end else begin
        rn[55:48] = rd_err;
        rn[127:56] = {analog_output_second_setting,
                      analog_output_first_setting, line_action_b,
                      line_action_a, expiry_count_limit,
                      timeout_action_flags};
        rl = `CTS_RD_RSP_LEN;
      end
      for (k = 6; k < 16; k = k + 1) begin
        if (k < rl) begin
          cs16 = cs16 + {8'h00, rn[8*k +: 8]};
        end
      end
      rn[47:32] = cs16;
      for (k = 1; k < 6; k = k + 1) begin
        cs8 = cs8 + rn[8*k +: 8];
      end
    end
    rn[7:0] = cs8;
  end

  // Response shifter; a new restart, configure or readback frame replaces an unfinished answer
  always @(posedge clk) begin
    if (!rst_n) begin
      resp_q <= 128'h0;
      resp_cnt_q <= 5'd0;
    end else if (fdone && rl != 5'd0) begin
      resp_q <= rn;
      resp_cnt_q <= rl;
    end else if (resp_cnt_q != 5'd0 && resp_ready) begin
      resp_q <= {8'h00, resp_q[127:8]};
      resp_cnt_q <= resp_cnt_q - 5'd1;
    end
  end

  // Register port: hold control, sticky expiry
  always @(posedge clk) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      if (wr && addr == `CTS_REG_CTRL) begin
        hold_q <= wdata[`CTS_CTRL_HOLD];
      end
      // Set wins over a clear in the same cycle
      if (fire_q) begin
        expired_q <= 1'b1;
      end else if (wr && addr == `CTS_REG_CTRL && wdata[`CTS_CTRL_CLR]) begin
        expired_q <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= 32'h00000000;
      if (rd) begin
        case (addr)
          `CTS_REG_CTRL: rdata_q <= {31'h0, hold_q};
          `CTS_REG_STAT: rdata_q <= {29'h0, |force_q, expired_q, sup_enabled};
          `CTS_REG_COUNT: rdata_q <= {16'h0000, count_q};
          `CTS_REG_LIMIT: rdata_q <= {16'h0000, expiry_count_limit};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign rdata = rdata_q;
  assign resp_byte = resp_q[7:0];
  assign resp_valid = resp_cnt_q != 5'd0;
  assign resp_last = resp_cnt_q == 5'd1;
  assign nv_commit = commit_q;
  assign nv_flags = timeout_action_flags;
  assign nv_limit = expiry_count_limit;
  assign nv_line_a = line_action_a;
  assign factory_restore = factory_q;
  assign reset_comm = rst_comm_q;
  assign reset_control = rst_ctrl_q;
  assign restart_hard = hard_q;
  assign restart_soft = soft_q;
  // RULE_09 line number to group mapping
  assign flexible_line_group_out = level_q[`CTS_GRP_EXT_LO-1:0];
  assign flexible_line_group_oe = force_q[`CTS_GRP_EXT_LO-1:0];
  assign extended_line_group_out = level_q[`CTS_GRP_CTRL_LO-1:`CTS_GRP_EXT_LO];
  assign extended_line_group_oe = force_q[`CTS_GRP_CTRL_LO-1:`CTS_GRP_EXT_LO];
  assign control_line_group_out = level_q[`CTS_GRP_MUX_LO-1:`CTS_GRP_CTRL_LO];
  assign control_line_group_oe = force_q[`CTS_GRP_MUX_LO-1:`CTS_GRP_CTRL_LO];
  assign multiplexer_line_group_out = level_q[`CTS_LINES-1:`CTS_GRP_MUX_LO];
  assign multiplexer_line_group_oe = force_q[`CTS_LINES-1:`CTS_GRP_MUX_LO];
  assign aout_first_code = ao1_q;
  assign aout_second_code = ao2_q;
  assign aout_enable = ao_en_q;
  assign aout_load = ao_load_q;
endmodule

/* cts_sup_sva.sv */
// Checker tying supervisor outputs to their causes
`timescale 1ns/1ps
module cts_sup_sva (
  input logic clk,
  input logic rst_n,
  input logic rx_valid,
  input logic rx_last,
  input logic [7:0] resp_byte,
  input logic resp_valid,
  input logic resp_ready,
  input logic nv_commit,
  input logic [7:0] nv_flags,
  input logic [15:0] nv_limit,
  input logic [7:0] nv_line_a,
  input logic factory_restore,
  input logic reset_comm,
  input logic reset_control,
  input logic restart_hard,
  input logic restart_soft,
  input logic [7:0] flexible_line_group_oe,
  input logic [7:0] extended_line_group_oe,
  input logic [3:0] control_line_group_oe,
  input logic [2:0] multiplexer_line_group_oe,
  input logic [11:0] aout_first_code,
  input logic [11:0] aout_second_code,
  input logic aout_enable,
  input logic aout_load
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Forced lines, all groups
  wire [22:0] oe_all = {multiplexer_line_group_oe, control_line_group_oe,
    extended_line_group_oe, flexible_line_group_oe};
  wire last_in = rx_valid & rx_last;
  // Answer two cycles after last byte
  property p_resp_rise; $rose(resp_valid) |-> $past(last_in, 2); endproperty
  a_resp_rise: assert property (p_resp_rise) else $error("resp start");
  // Stalled byte holds
  property p_resp_hold; resp_valid && !resp_ready |=> resp_valid && $stable(resp_byte); endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("resp moved");
  // Restart pulses follow a frame
  property p_restart; restart_hard || restart_soft |-> $past(last_in, 2) || $past(last_in, 3);
  endproperty
  a_restart: assert property (p_restart) else $error("stray restart");
  // Forcing sticks until reset
  property p_oe_keep; (~oe_all & $past(oe_all)) == 23'h0; endproperty
  a_oe_keep: assert property (p_oe_keep) else $error("line released");
  // Analog outputs move with a load
  property p_code_load; $changed({aout_first_code, aout_second_code, aout_enable}) |-> aout_load;
  endproperty
  a_code_load: assert property (p_code_load) else $error("analog no load");
  // Jumper boot stores zeros
  property p_factory;
    factory_restore |-> nv_commit && nv_flags == 8'h00 && nv_limit == 16'h0 && nv_line_a == 8'h00;
  endproperty
  a_factory: assert property (p_factory) else $error("jumper not zeroed");
  // Zero flags, no action
  property p_idle;
    $past(nv_flags == 8'h00, 2) && nv_flags == 8'h00 |-> !(reset_comm || reset_control || aout_load);
  endproperty
  a_idle: assert property (p_idle) else $error("action when off");
  property p_comm; reset_comm |-> $past(nv_flags[6], 2); endproperty
  a_comm: assert property (p_comm) else $error("stray comm reset");
  property p_ctrl; reset_control |-> $past(nv_flags[5], 2); endproperty
  a_ctrl: assert property (p_ctrl) else $error("stray ctrl reset");
  property p_aload; aout_load |-> $past(nv_flags[1] | nv_flags[0], 2); endproperty
  a_aload: assert property (p_aload) else $error("stray analog load");
endmodule
bind cts_supervisor cts_sup_sva u_sva (.*);

/* cts_host_model.sv */
// Host model: sends command frames and collects the answers
`timescale 1ns/1ps
module cts_host_model (
  input wire clk,
  output logic [7:0] rx_byte = 8'h00,
  output logic rx_valid = 1'b0,
  output logic rx_last = 1'b0,
  input wire [7:0] resp_byte,
  input wire resp_valid,
  input wire resp_last,
  output logic resp_ready = 1'b0
);
  logic slow = 1'b0;
  // Slow host: ready every other cycle
  always @(posedge clk) resp_ready <= slow ? ~resp_ready : 1'b1;
  // any frame keeps the count cleared
  task automatic xfer(input logic [7:0] f [16], input int n, input bit want,
    output logic [7:0] r [16], output int rn);
    rn = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_byte <= f[i];
      rx_valid <= 1'b1;
      rx_last <= (i == n - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_byte <= ~rx_byte; // No stale byte
    for (int w = 0; want && w < 300; w++) begin
      @(posedge clk);
      if (resp_valid === 1'b1 && resp_ready === 1'b1) begin
        r[rn] = resp_byte;
        rn++;
        if (resp_last === 1'b1) break;
      end
    end
  endtask
endmodule

/* testbench.sv */
// Self-checking bench for the timeout supervisor
`timescale 1ns/1ps
`include "cts_regs.vh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s exp %h got %h", nm, ex, got); end end
module testbench;
  typedef logic [7:0] cts_frm_t [16];
  localparam int TK = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic defaults_jumper = 1'b0;
  logic [7:0] nv_flags_in = 8'h08;
  logic [15:0] nv_limit_in = 16'h0002;
  logic [7:0] nv_line_a_in = 8'h85;
  wire [31:0] rdata;
  wire [7:0] rx_byte, resp_byte, nv_flags, nv_line_a;
  wire [15:0] nv_limit;
  wire rx_valid, rx_last, resp_valid, resp_last, resp_ready, nv_commit, factory_restore;
  wire reset_comm, reset_control, restart_hard, restart_soft, aout_enable, aout_load;
  wire [7:0] flexible_line_group_out, flexible_line_group_oe;
  wire [7:0] extended_line_group_out, extended_line_group_oe;
  wire [3:0] control_line_group_out, control_line_group_oe;
  wire [2:0] multiplexer_line_group_out, multiplexer_line_group_oe;
  wire [11:0] aout_first_code, aout_second_code;
  int miscompares;
  int total_checks;
  int n_com, n_fac, n_rc, n_rx, n_hd, n_sf, n_ld;
  int i, rn, n0;
  logic [31:0] d;
  cts_frm_t f, r, x, keep;
  // Short tick, brief run
  cts_supervisor #(.TICK_CYCLES(TK)) i_dut (.*);
  cts_host_model i_host (.*);
  always #12.5 clk = ~clk;
  // Pulse tallies
  always @(posedge clk) begin
    n_com += nv_commit;
    n_fac += factory_restore;
    n_rc += reset_comm;
    n_rx += reset_control;
    n_hd += restart_hard;
    n_sf += restart_soft;
    n_ld += aout_load;
  end
  task automatic give_verdict;
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset(input logic j);
    defaults_jumper <= j;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data only in cycle after strobe
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    rreg(a);
    `CHK(nm, e, d)
  endtask
  // Header byte sum, body word sum
  function automatic cts_frm_t seal(cts_frm_t b, int n, bit ext);
    logic [15:0] s;
    logic [7:0] c;
    s = 16'h0;
    c = 8'h0;
    if (ext) begin
      for (int j = 6; j < n; j++) s += b[j];
      b[4] = s[7:0];
      b[5] = s[15:8];
    end
    for (int j = 1; j < (ext ? 6 : 4); j++) c += b[j];
    b[0] = c;
    return b;
  endfunction
  task automatic hdr(input logic [7:0] b1, b2, b3);
    f = '{default: 8'h00};
    {f[1], f[2], f[3]} = {b1, b2, b3};
  endtask
  task automatic cfg(input logic [7:0] fl, la, lb, input logic [15:0] lm, a0, a1);
    hdr(`CTS_EXT_CMD, `CTS_CFG_B2, `CTS_SUP_B3);
    {f[7], f[8], f[9], f[10], f[11]} = {fl, lm[7:0], lm[15:8], la, lb};
    {f[12], f[13], f[14], f[15]} = {a0[7:0], a0[15:8], a1[7:0], a1[15:8]};
    f = seal(f, 16, 1'b1);
  endtask
  task automatic cmp(input int n);
    for (int j = 0; j < n; j++) `CHK("rsp", x[j], r[j])
  endtask
  task automatic run(input int n, input int en);
    i_host.xfer(f, n, en > 0, r, rn);
    `CHK("rsp_len", en, rn)
  endtask
  // Configure; echo with flags
  task automatic cfg_run;
    run(16, 8);
    x = seal(f, 8, 1'b1);
    cmp(8);
  endtask
  task automatic rdback;
    hdr(`CTS_EXT_CMD, `CTS_RD_B2, `CTS_SUP_B3);
    f = seal(f, 6, 1'b1);
    run(6, 16);
    x = keep;
    cmp(16);
  endtask
  task automatic wait_ld(input int v);
    for (int j = 0; j < 300 && n_ld < v; j++) @(posedge clk);
    `CHK("load_wait", 1'b1, n_ld >= v)
    if (n_ld < v) give_verdict();
  endtask
  initial begin
    do_reset(1'b0);
    rchk("limit", `CTS_REG_LIMIT, 32'h2);
    rchk("stat", `CTS_REG_STAT, 32'h1);
    for (i = 0; i < 200 && flexible_line_group_oe !== 8'h20; i++) @(posedge clk);
    `CHK("span", 1'b1, i > TK && i < 3 * TK + 4)
    `CHK("line_a", 8'h20, flexible_line_group_out)
    rchk("stat", `CTS_REG_STAT, 32'h7);
    wreg(`CTS_REG_CTRL, 32'h2);
    rchk("stat_clr", `CTS_REG_STAT, 32'h5);
    wreg(4'h2, 32'hffffffff);
    rchk("unmapped", 4'h2, 32'h0);
    n0 = n_com;
    i_host.slow = 1'b1;
    cfg(8'h7b, 8'h11, 8'h96, 16'h0001, 16'h0123, 16'h8abc);
    keep = f;
    cfg_run();
    `CHK("commit", n0 + 1, n_com)
    `CHK("nv", {8'h7b, 16'h0001, 8'h11}, {nv_flags, nv_limit, nv_line_a})
    cfg_run();
    `CHK("no_commit", n0 + 1, n_com)
    i_host.slow = 1'b0;
    wait_ld(n_ld + 1);
    `CHK("codes", {12'h123, 12'habc, 1'b1}, {aout_first_code, aout_second_code, aout_enable})
    `CHK("ctrl_grp", {4'h2, 4'h0}, {control_line_group_oe, control_line_group_out})
    `CHK("mux_grp", {3'h4, 3'h4}, {multiplexer_line_group_oe, multiplexer_line_group_out})
    `CHK("sticky", 8'h20, flexible_line_group_oe)
    `CHK("resets", 1'b1, n_rc > 0 && n_rx > 0)
    cfg(8'h0a, 8'h8a, 8'h96, 16'h0001, 16'h0321, 16'h0055);
    keep = f;
    cfg_run();
    wait_ld(n_ld + 2);
    `CHK("codes2", {12'h123, 12'h055, 1'b0}, {aout_first_code, aout_second_code, aout_enable})
    `CHK("ext_grp", {8'h04, 8'h04}, {extended_line_group_oe, extended_line_group_out})
    rdback();
    for (int m = 0; m < 2; m++) begin
      cfg(m ? 8'h81 : 8'h01, 8'h00, 8'h00, 16'h0005, 16'h0000, 16'h0000);
      f[0] = m ? f[0] : ~f[0];
      run(16, 8);
      `CHK("err", m ? `CTS_ERR_PARAM : `CTS_ERR_CSUM, r[6])
    end
    rdback();
    for (int b = 1; b < 4; b++) begin
      hdr(`CTS_RST_B1, b[7:0], `CTS_RST_B3);
      f = seal(f, 4, 1'b0);
      x = f;
      x[2] = 8'h00;
      x = seal(x, 4, 1'b0);
      run(4, 4);
      cmp(4);
    end
    `CHK("hard_soft", {32'd2, 32'd2}, {n_hd, n_sf})
    cfg(8'h40, 8'h00, 8'h00, 16'd100, 16'h0000, 16'h0000);
    cfg_run();
    repeat (3 * TK) @(posedge clk);
    rreg(`CTS_REG_COUNT);
    `CHK("count_up", 1'b1, d >= 2)
    hdr(8'h77, 8'h00, 8'h00);
    run(4, 0);
    rreg(`CTS_REG_COUNT);
    `CHK("count_clr", 1'b1, d < 2)
    cfg(8'h00, 8'h00, 8'h00, 16'h0001, 16'h0000, 16'h0000);
    cfg_run();
    repeat (3 * TK) @(posedge clk);
    rchk("count_off", `CTS_REG_COUNT, 32'h0);
    rreg(`CTS_REG_STAT);
    `CHK("stat_off", 1'b0, d[`CTS_STAT_EN])
    do_reset(1'b1);
    `CHK("factory", 1, n_fac)
    `CHK("oe_clr", 8'h00, flexible_line_group_oe)
    cfg(8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000);
    keep = f;
    rdback();
    give_verdict();
  end
endmodule
